// ===== tb/testbench.sv
/*
  Self-checking bench for the serial port core: register port, modem status,
  scratch and fractional divide registers, pin mux, interrupt. Assumes the modem peer model.
*/
`timescale 1ns/10ps
`include "uamsf_defs.svh"
module testbench import uamsf_pkg::*;;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [31:0] rdata;
  logic [9:0] pin_in;
  uamsf_pins_s pins;
  logic irq;
  uamsf_modem_s line_cmd = 4'h0;
  int err_total = 0;
  int check_count = 0;
  logic [31:0] v;
  // plain rows: address, write data, expected read-back
  logic [31:0] row_a [7] = '{`UAMSF_OFF_SCR, `UAMSF_OFF_SCR, `UAMSF_OFF_FRAC,
    `UAMSF_OFF_FRAC, `UAMSF_OFF_FRAC, 32'hFFFF0740, `UAMSF_OFF_MS};
  logic [31:0] row_w [7] = '{32'h0000_00AA, 32'h0000_0055, 32'h0000_FFFF,
    32'h0000_8801, 32'h0000_8005, 32'h0000_0012, 32'h0000_00FF};
  logic [31:0] row_e [7] = '{32'h0000_00AA, 32'h0000_0055, 32'h0000_9FFF,
    32'h0000_8801, 32'h0000_8005, 32'h0000_0000, 32'h0000_0000};
  // modem rows: line levels {dcd,ri,dsr,cts} and the status byte they should give
  logic [3:0] mrow_l [7] = '{4'h8, 4'h8, 4'hC, 4'h8, 4'hA, 4'hB, 4'h3};
  logic [7:0] mrow_e [7] = '{8'h88, 8'h80, 8'hC4, 8'h80, 8'hA2, 8'hB1, 8'h38};

  uamsf_core uut (.clk_sys(clk_sys), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .pin_in(pin_in), .pins(pins),
    .irq(irq));
  uamsf_modem_peer peer (.clk_sys(clk_sys), .line_cmd(line_cmd), .pins(pins),
    .pin_in(pin_in));

  // 20 MHz system clock
  always #25 clk_sys = ~clk_sys;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle write strobe, changed just after an edge
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    #1;
    d = rdata;
  endtask

  // write then read back with no gap: the read strobe rises as the write strobe falls
  task automatic wr_rd(input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    #1;
    q = rdata;
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // a run takes about 750 cycles; cut a hang short
  initial begin
    #(50 * 5000);
    err_total++;
    finish_test();
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    #1;
    chk("pins_oe_reset", 32'h0, {22'h0, pins.oe});
    chk("irq_reset", 32'h0, {31'h0, irq});
    rd(`UAMSF_OFF_MS, v);
    chk("ms_reset", 32'h0, v);
    rd(`UAMSF_OFF_SCR, v);
    chk("scr_reset", 32'h0, v);
    rd(`UAMSF_OFF_FRAC, v);
    chk("frac_reset", 32'h0, v);
    // ordinary register rows, read back with no gap after the write
    for (int i = 0; i < 7; i++) begin
      wr_rd(row_a[i], row_w[i], v);
      chk("reg_row", row_e[i], v);
    end
    // pins 0..7 to the serial port function (code 01), 8 and 9 to the alternate serial pair
    wr(`UAMSF_OFF_MUX, 32'h000A_5555);
    wr(`UAMSF_OFF_MCR, 32'h0000_0003);
    wait_clk(2);
    chk("pins_oe_mux", 32'h286, {22'h0, pins.oe});
    chk("pins_out_mux", 32'h286, {22'h0, pins.out & 10'h286});
    // parity on in line control, so network mode has a parity bit to suppress
    wr(`UAMSF_OFF_LCR, 32'h0000_000B);
    // net mode with the pin driver off floats the transmit pin, then back on
    wr(`UAMSF_OFF_NET, 32'h0000_0080);
    wait_clk(2);
    chk("tx_oe_net", 32'h0, {31'h0, pins.oe[1]});
    wr(`UAMSF_OFF_NET, 32'h0000_0084);
    wait_clk(2);
    chk("tx_oe_net_drv", 32'h1, {31'h0, pins.oe[1]});
    wr(`UAMSF_OFF_NET, 32'h0000_0004);
    // modem line rows: live levels and change flags, each read clears the flags
    for (int i = 0; i < 7; i++) begin
      @(posedge clk_sys);
      line_cmd <= mrow_l[i];
      wait_clk(4);
      rd(`UAMSF_OFF_MS, v);
      chk("ms_row", {24'h0, mrow_e[i]}, v);
    end
    // unmasked modem change raises the interrupt, write-one clears it
    wr(`UAMSF_OFF_IST, 32'h0000_000F);
    wr(`UAMSF_OFF_IMSK, 32'h0000_0004);
    @(posedge clk_sys);
    line_cmd <= 4'h2;
    wait_clk(5);
    chk("irq_set", 32'h1, {31'h0, irq});
    rd(`UAMSF_OFF_IST, v);
    chk("ist_set", 32'h4, v);
    wr(`UAMSF_OFF_IST, 32'h0000_0004);
    wait_clk(2);
    chk("irq_clr", 32'h0, {31'h0, irq});
    // masked event still sets status but leaves the line low
    wr(`UAMSF_OFF_IMSK, 32'h0);
    @(posedge clk_sys);
    line_cmd <= 4'h3;
    wait_clk(5);
    chk("irq_masked", 32'h0, {31'h0, irq});
    rd(`UAMSF_OFF_IST, v);
    chk("ist_masked", 32'h4, v);
    // a change landing on the same cycle as a status read must not be lost
    rd(`UAMSF_OFF_MS, v);
    @(posedge clk_sys);
    line_cmd <= 4'h2;
    rd(`UAMSF_OFF_MS, v);
    chk("ms_race_read", 32'h30, v);
    wait_clk(3);
    rd(`UAMSF_OFF_MS, v);
    chk("ms_race", 32'h21, v);
    // nine-bit network frame, marker set: data msb 0 on bit 8, marker 1 on bit 9
    // a bit is 16 ticks of about four clocks each, so samples sit near mid-bit
    wr(`UAMSF_OFF_NET, 32'h0000_008D);
    wr(`UAMSF_OFF_DATA, 32'h0000_0025);
    wait_clk(3);
    chk("tx_start", 32'h0, {31'h0, pins.out[1]});
    wait_clk(540);
    chk("tx_data_msb", 32'h0, {31'h0, pins.out[1]});
    wait_clk(64);
    chk("tx_addr_mark", 32'h1, {31'h0, pins.out[1]});
    // second reset in mid-run, mid-frame, restores the defaults
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(`UAMSF_OFF_SCR, v);
    chk("scr_rereset", 32'h0, v);
    chk("pins_oe_rereset", 32'h0, {22'h0, pins.oe});
    chk("pins_out_rereset", 32'h0, {22'h0, pins.out});
    finish_test();
  end
endmodule

// ===== tb/uamsf_modem_peer.sv
/*
  Line-side partner: a modem that drives its status lines onto the shared pins.
  Assumes the testbench commands the line levels and everything runs on clk_sys.
*/
`timescale 1ns/10ps
module uamsf_modem_peer import uamsf_pkg::*; (
  // clock
  input wire logic clk_sys,
  // commanded modem line levels
  input wire uamsf_modem_s line_cmd,
  // pin side
  input wire uamsf_pins_s pins,
  output logic [9:0] pin_in
);
  uamsf_modem_s line_r;

  // lines move just after an edge, like a modem clocked from the same board clock
  always_ff @(posedge clk_sys) begin
    line_r <= line_cmd;
  end

  // driven pins read back; other undriven ones sit at an assumed pull-up, so rx idles high; pins 3..6 always carry the modem lines
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      pin_in[i] = pins.oe[i] ? pins.out[i] : 1'b1;
    end
    pin_in[3] = line_r.cts;
    pin_in[4] = line_r.ri;
    pin_in[5] = line_r.dcd;
    pin_in[6] = line_r.dsr;
  end
endmodule

// ===== verilog/uamsf_core.sv
/*
  Serial port core: register port, baud generator (integer or fractional),
  transmitter, receiver, modem status, network bits, pin mux and interrupt.
  Assumes pin inputs synchronous to clk_sys and a master that never waits.
*/
`timescale 1ns/10ps
`include "uamsf_defs.svh"
module uamsf_core import uamsf_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // register port
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata,
  // shared pins
  input wire logic [9:0] pin_in,
  output uamsf_pins_s pins,
  // interrupt
  output logic irq
);
  function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
    hit = (a == off);
  endfunction

  function automatic uamsf_pin_e code_of(input logic [19:0] m, input int i);
    code_of = uamsf_pin_e'(m[2*i +: 2]);
  endfunction

  function automatic logic par_of(input logic [7:0] d, input logic [3:0] w, input logic ev);
    logic [7:0] m;
    m = d & (8'hFF >> (4'h8 - w));
    par_of = ev ? ^m : ~^m;
  endfunction

  // start bit, data lsb first, optional ninth or parity bit, then stop ones
  function automatic logic [11:0] tx_frame(input logic [7:0] d, input logic [3:0] w,
      input logic n9, input logic address_marker_bit, input logic pe, input logic par);
    logic [11:0] f;
    logic [3:0] p;
    f = 12'hFFF;
    f[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i < w) begin
        f[1+i] = d[i];
      end
    end
    p = w + 4'h1;
    if (n9) begin
      f[p] = address_marker_bit;
      p = p + 4'h1;
    end
    if (pe) begin
      f[p] = par;
    end
    tx_frame = f;
  endfunction

  logic [15:0] dl_r, frac_r;
  logic [7:0] lcr_r, net_r, scr_r, thr_r, rbr_r;
  logic [1:0] mcr_r;
  logic [19:0] mux_r;
  logic [3:0] ist_r, imsk_r, dflag_r, mset, ev;
  logic thr_full_r, dr_r, ovr_r, pe_r, fe_r, rx9_r;
  uamsf_modem_s mdm_in, live_r;
  logic [29:0] acc_r, per;
  logic [30:0] acc_sum;
  logic tick_r;
  logic [15:0] dl_eff;
  logic [2:0] m_eff;
  logic [13:0] frac_mul;
  uamsf_tx_e tx_st_r;
  logic [11:0] tx_sh_r;
  logic [3:0] tx_cnt_r, tx_bit_r, tx_len_r;
  uamsf_rx_e rx_st_r;
  logic [10:0] rx_sh_r, rx_f;
  logic [3:0] rx_cnt_r, rx_bit_r;
  logic net_mode, ninth, par_en, tx_line, tx_oe, rxd, tx_done, rx_done, rx_err;
  logic [3:0] wl, rx_need, tx_len;
  logic [7:0] rx_d;
  logic [9:0] u_out, u_oe, a_out, a_oe, po_nxt, poe_nxt;
  logic wr_data, wr_div, wr_lcr, wr_mcr, wr_scr, wr_net, wr_frac, wr_ist, wr_imsk, wr_mux;
  logic rd_data, rd_lsr, rd_ms;
  logic [31:0] rd_val;

  // address decode of both strobes
  assign wr_data = wr_stb & hit(addr, `UAMSF_OFF_DATA);
  assign wr_div = wr_stb & hit(addr, `UAMSF_OFF_DIV);
  assign wr_lcr = wr_stb & hit(addr, `UAMSF_OFF_LCR);
  assign wr_mcr = wr_stb & hit(addr, `UAMSF_OFF_MCR);
  assign wr_scr = wr_stb & hit(addr, `UAMSF_OFF_SCR);
  assign wr_net = wr_stb & hit(addr, `UAMSF_OFF_NET);
  assign wr_frac = wr_stb & hit(addr, `UAMSF_OFF_FRAC);
  assign wr_ist = wr_stb & hit(addr, `UAMSF_OFF_IST);
  assign wr_imsk = wr_stb & hit(addr, `UAMSF_OFF_IMSK);
  assign wr_mux = wr_stb & hit(addr, `UAMSF_OFF_MUX);
  assign rd_data = rd_stb & hit(addr, `UAMSF_OFF_DATA);
  assign rd_lsr = rd_stb & hit(addr, `UAMSF_OFF_LSR);
  assign rd_ms = rd_stb & hit(addr, `UAMSF_OFF_MS);

  // software-written configuration; reserved frac bits 14:13 never stored
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dl_r <= `UAMSF_RST_DIV;
      frac_r <= `UAMSF_RST_FRAC;
      lcr_r <= `UAMSF_RST_LCR;
      mcr_r <= 2'h0;
      scr_r <= `UAMSF_RST_SCR;
      net_r <= `UAMSF_RST_NET;
      imsk_r <= 4'h0;
      mux_r <= 20'h00000;
    end else begin
      if (wr_div) dl_r <= wdata[15:0];
      if (wr_frac) frac_r <= {wdata[15], 2'h0, wdata[12:0]};
      if (wr_lcr) lcr_r <= wdata[7:0];
      if (wr_mcr) mcr_r <= wdata[1:0];
      if (wr_scr) scr_r <= wdata[7:0];
      if (wr_net) net_r <= wdata[7:0];
      if (wr_imsk) imsk_r <= wdata[3:0];
      if (wr_mux) mux_r <= wdata[19:0];
    end
  end

  // frame shape; network mode drops parity and may add the marker bit
  assign net_mode = net_r[`UAMSF_NET_NETWORK_MODE_ENABLE];
  assign ninth = net_mode & (net_r[`UAMSF_NET_E9BT] | net_r[`UAMSF_NET_NINE_BIT_WORD_SELECT]);
  assign par_en = lcr_r[`UAMSF_LCR_PEN] & ~net_mode;
  assign wl = ninth ? 4'h8 : 4'h5 + {2'h0, lcr_r[1:0]};
  assign rx_need = wl + {3'h0, ninth} + {3'h0, par_en} + 4'h1;
  assign tx_len = rx_need + 4'h1 + {3'h0, lcr_r[`UAMSF_LCR_STB]};

  // 16x tick: period in 1/2048 cycles, integer divisor is the M=1,N=0 case
  assign dl_eff = (dl_r == 16'h0000) ? 16'h0001 : dl_r;
  assign m_eff = (frac_r[12:11] == 2'h0) ? 3'h4 : {1'b0, frac_r[12:11]};
  assign frac_mul = frac_r[`UAMSF_FRAC_EN] ? {m_eff, 11'h000} + {3'h0, frac_r[10:0]}
                                           : `UAMSF_FRAC_ONE;
  assign per = dl_eff * frac_mul;
  assign acc_sum = {1'b0, acc_r} + `UAMSF_ACC_STEP;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      acc_r <= 30'h0;
      tick_r <= 1'b0;
    end else if (acc_sum >= {1'b0, per}) begin
      acc_r <= 30'(acc_sum - {1'b0, per});
      tick_r <= 1'b1;
    end else begin
      acc_r <= acc_sum[29:0];
      tick_r <= 1'b0;
    end
  end

  // transmitter: holding byte is loaded into the shifter when idle
  assign tx_line = tx_sh_r[0];
  assign tx_done = (tx_st_r == UAMSF_TX_SEND) & tick_r & (tx_cnt_r == `UAMSF_TICK_LAST) &
                   (tx_bit_r == tx_len_r - 4'h1);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tx_st_r <= UAMSF_TX_IDLE;
      tx_sh_r <= 12'hFFF;
      tx_cnt_r <= 4'h0;
      tx_bit_r <= 4'h0;
      tx_len_r <= 4'h0;
    end else begin
      unique case (tx_st_r)
        UAMSF_TX_IDLE: begin
          if (thr_full_r) begin
            tx_sh_r <= tx_frame(thr_r, wl, ninth, net_r[`UAMSF_NET_NAB], par_en,
                                par_of(thr_r, wl, lcr_r[`UAMSF_LCR_EPS]));
            tx_len_r <= tx_len;
            tx_cnt_r <= 4'h0;
            tx_bit_r <= 4'h0;
            tx_st_r <= UAMSF_TX_SEND;
          end
        end
        UAMSF_TX_SEND: begin
          if (tick_r) begin
            tx_cnt_r <= tx_cnt_r + 4'h1;
            if (tx_cnt_r == `UAMSF_TICK_LAST) begin
              tx_sh_r <= {1'b1, tx_sh_r[11:1]};
              tx_bit_r <= tx_bit_r + 4'h1;
              if (tx_done) tx_st_r <= UAMSF_TX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // holding register; a write in the load cycle refills it
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      thr_r <= 8'h00;
      thr_full_r <= 1'b0;
    end else if (wr_data) begin
      thr_r <= wdata[7:0];
      thr_full_r <= 1'b1;
    end else if (tx_st_r == UAMSF_TX_IDLE) begin
      thr_full_r <= 1'b0;
    end
  end

  // receiver: start checked at mid-bit, then one sample each bit time
  assign rx_done = (rx_st_r == UAMSF_RX_DATA) & tick_r & (rx_cnt_r == `UAMSF_TICK_LAST) &
                   (rx_bit_r == rx_need - 4'h1);
  assign rx_f = {rxd, rx_sh_r[10:1]} >> (4'hB - rx_need);
  assign rx_d = rx_f[7:0] & (8'hFF >> (4'h8 - wl));
  assign rx_err = rx_done & (~rxd | (par_en & (rx_f[wl] != par_of(rx_d, wl, lcr_r[`UAMSF_LCR_EPS]))));

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rx_st_r <= UAMSF_RX_IDLE;
      rx_sh_r <= 11'h7FF;
      rx_cnt_r <= 4'h0;
      rx_bit_r <= 4'h0;
    end else begin
      unique case (rx_st_r)
        UAMSF_RX_IDLE: begin
          if (!rxd) begin
            rx_st_r <= UAMSF_RX_START;
            rx_cnt_r <= 4'h0;
          end
        end
        UAMSF_RX_START: begin
          if (tick_r) begin
            rx_cnt_r <= rx_cnt_r + 4'h1;
            if (rx_cnt_r == `UAMSF_TICK_MID) begin
              rx_st_r <= rxd ? UAMSF_RX_IDLE : UAMSF_RX_DATA; // glitch rejected
              rx_cnt_r <= 4'h0;
              rx_bit_r <= 4'h0;
            end
          end
        end
        default: begin // UAMSF_RX_DATA; the unused code also lands here
          if (tick_r) begin
            rx_cnt_r <= rx_cnt_r + 4'h1;
            if (rx_cnt_r == `UAMSF_TICK_LAST) begin
              rx_sh_r <= {rxd, rx_sh_r[10:1]};
              rx_bit_r <= rx_bit_r + 4'h1;
              if (rx_done) rx_st_r <= UAMSF_RX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // received word and line flags; a new event beats a clearing read
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rbr_r <= 8'h00;
      rx9_r <= 1'b0;
      dr_r <= 1'b0;
      ovr_r <= 1'b0;
      pe_r <= 1'b0;
      fe_r <= 1'b0;
    end else begin
      if (rx_done) begin
        rbr_r <= rx_d;
        rx9_r <= ninth & rx_f[wl];
      end
      dr_r <= rx_done | (dr_r & ~rd_data);
      ovr_r <= (rx_done & dr_r & ~rd_data) | (ovr_r & ~rd_lsr);
      pe_r <= (rx_done & par_en & (rx_f[wl] != par_of(rx_d, wl, lcr_r[`UAMSF_LCR_EPS]))) |
              (pe_r & ~rd_lsr);
      fe_r <= (rx_done & ~rxd) | (fe_r & ~rd_lsr);
    end
  end

  // modem inputs read as inactive when their pin is not in code 01
  assign mdm_in.cts = (code_of(mux_r, 3) == UAMSF_PIN_UART) & pin_in[3];
  assign mdm_in.ri = (code_of(mux_r, 4) == UAMSF_PIN_UART) & pin_in[4];
  assign mdm_in.dcd = (code_of(mux_r, 5) == UAMSF_PIN_UART) & pin_in[5];
  assign mdm_in.dsr = (code_of(mux_r, 6) == UAMSF_PIN_UART) & pin_in[6];
  assign rxd = (code_of(mux_r, 0) == UAMSF_PIN_UART) ? pin_in[0] :
               (code_of(mux_r, 8) == UAMSF_PIN_ALT) ? pin_in[8] : 1'b1;
  assign mset = {mdm_in.dcd ^ live_r.dcd, mdm_in.ri & ~live_r.ri,
                 mdm_in.dsr ^ live_r.dsr, mdm_in.cts ^ live_r.cts};

  // change flags: set wins so an edge in the read cycle survives
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      live_r <= '0;
      dflag_r <= 4'h0;
    end else begin
      live_r <= mdm_in;
      dflag_r <= mset | (dflag_r & {4{~rd_ms}});
    end
  end

  // sticky events, write one to clear, set beats clear
  assign ev = {rx_err, |mset, tx_done, rx_done};
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ist_r <= 4'h0;
      irq <= 1'b0;
    end else begin
      ist_r <= ev | (ist_r & ~(wr_ist ? wdata[3:0] : 4'h0));
      irq <= |(ist_r & imsk_r);
    end
  end

  // per-function drive; tx only three-states in network mode with driver off
  assign tx_oe = ~net_mode | net_r[`UAMSF_NET_ETD];
  assign u_out = {2'h0, mcr_r[`UAMSF_MCR_DTR], 4'h0, mcr_r[`UAMSF_MCR_RTS], tx_line, 1'b0};
  assign u_oe = {2'h0, 1'b1, 4'h0, 1'b1, tx_oe, 1'b0};
  assign a_out = {tx_line, 9'h000};
  assign a_oe = {tx_oe, 9'h000};

  // GPIO and logic-array codes belong to other blocks, so pins stay undriven
  for (genvar g = 0; g < 10; g++) begin : g_pin
    assign po_nxt[g] = (code_of(mux_r, g) == UAMSF_PIN_UART) ? u_out[g] :
                       (code_of(mux_r, g) == UAMSF_PIN_ALT) ? a_out[g] : 1'b0;
    assign poe_nxt[g] = (code_of(mux_r, g) == UAMSF_PIN_UART) ? u_oe[g] :
                        (code_of(mux_r, g) == UAMSF_PIN_ALT) ? a_oe[g] : 1'b0;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pins <= '0;
    end else begin
      pins.out <= po_nxt;
      pins.oe <= poe_nxt;
    end
  end

  // read mux; data stand only in the cycle after the strobe
  always_comb begin
    rd_val = 32'h0;
    if (hit(addr, `UAMSF_OFF_DATA)) rd_val = {24'h0, rbr_r};
    if (hit(addr, `UAMSF_OFF_DIV)) rd_val = {16'h0, dl_r};
    if (hit(addr, `UAMSF_OFF_LCR)) rd_val = {24'h0, lcr_r};
    if (hit(addr, `UAMSF_OFF_MCR)) rd_val = {30'h0, mcr_r};
    if (hit(addr, `UAMSF_OFF_LSR)) begin
      rd_val = {24'h0, rx9_r, tx_st_r == UAMSF_TX_IDLE && !thr_full_r, !thr_full_r,
                1'b0, fe_r, pe_r, ovr_r, dr_r};
    end
    if (hit(addr, `UAMSF_OFF_MS)) rd_val = {24'h0, live_r, dflag_r};
    if (hit(addr, `UAMSF_OFF_SCR)) rd_val = {24'h0, scr_r};
    if (hit(addr, `UAMSF_OFF_NET)) rd_val = {24'h0, net_r};
    if (hit(addr, `UAMSF_OFF_FRAC)) rd_val = {16'h0, frac_r};
    if (hit(addr, `UAMSF_OFF_IST)) rd_val = {28'h0, ist_r};
    if (hit(addr, `UAMSF_OFF_IMSK)) rd_val = {28'h0, imsk_r};
    if (hit(addr, `UAMSF_OFF_MUX)) rd_val = {12'h0, mux_r};
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata <= 32'h0;
    end else begin
      rdata <= rd_stb ? rd_val : 32'h0;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  AST_MS_LIVE: assert property (rd_ms |=> rdata[7:4] == $past(live_r))
    else $error("modem status live bits wrong");
  AST_DCD_SET: assert property (mdm_in.dcd != live_r.dcd |=> dflag_r[3])
    else $error("carrier change not flagged");
  AST_RI_RISE: assert property (!live_r.ri ##1 live_r.ri |-> dflag_r[2])
    else $error("ring edge not flagged");
  AST_RI_FALL: assert property (rd_ms && !mset[2] |=> !dflag_r[2])
    else $error("ring flag set without rising edge");
  AST_DSR_SET: assert property ($changed(live_r.dsr) |-> dflag_r[1])
    else $error("dsr change not flagged");
  AST_CTS_SET: assert property ($changed(live_r.cts) |-> dflag_r[0])
    else $error("cts change not flagged");
  AST_MS_CLR: assert property (rd_ms && mset == 4'h0 |=> dflag_r == 4'h0)
    else $error("status read did not clear flags");
  AST_KEEP: assert property (rd_ms && mset[0]
    |=> dflag_r[0] ##1 dflag_r[0] || $past(rd_ms)) else $error("change lost during read");
  AST_SCR: assert property (wr_scr ##1 rd_stb && hit(addr, `UAMSF_OFF_SCR)
    |=> rdata[7:0] == $past(wdata[7:0], 2)) else $error("scratch readback wrong");
  AST_STD_DIV: assert property (!frac_r[15] |-> per == {3'h0, dl_eff, 11'h000})
    else $error("integer divisor period wrong");
  AST_M_ZERO: assert property (frac_r[15] && frac_r[12:11] == 2'h0
    |-> frac_mul == {3'h4, frac_r[10:0]}) else $error("M of zero not taken as four");
  AST_N: assert property (frac_r[15] |-> frac_mul[10:0] == frac_r[10:0])
    else $error("N field misplaced");
  AST_NOPAR: assert property (net_mode |-> rx_need == wl + {3'h0, ninth} + 4'h1)
    else $error("parity present in network mode");
  AST_NAB: assert property (tx_st_r == UAMSF_TX_IDLE && thr_full_r && ninth
    |=> tx_sh_r[9] == $past(net_r[0])) else $error("address marker wrong");
  AST_PIN_RST: assert property (mux_r == 20'h00000 |=> pins.oe == 10'h000)
    else $error("gpio code drives a pin");
  AST_PIN_TX: assert property (code_of(mux_r, 1) == UAMSF_PIN_UART
    |=> pins.out[1] == $past(tx_line)) else $error("tx pin not following line");
  AST_IRQ: assert property (|(ist_r & imsk_r) |=> irq)
    else $error("interrupt not raised");

  COV_RX: cover property (rx_done && !rx_err);
  COV_TX: cover property (tx_done);
  COV_FRAC: cover property (frac_r[15] && tick_r);
  COV_KEEP: cover property (rd_ms && mset != 4'h0);
endmodule

// ===== verilog/uamsf_defs.svh
/*
  Offsets, field positions, reset values and tick constants of the serial port block.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef UAMSF_DEFS_SVH
`define UAMSF_DEFS_SVH
`define UAMSF_OFF_DATA 32'hFFFF0700
`define UAMSF_OFF_DIV 32'hFFFF0704
`define UAMSF_OFF_LCR 32'hFFFF070C
`define UAMSF_OFF_MCR 32'hFFFF0710
`define UAMSF_OFF_LSR 32'hFFFF0714
`define UAMSF_OFF_MS 32'hFFFF0718
`define UAMSF_OFF_SCR 32'hFFFF071C
`define UAMSF_OFF_NET 32'hFFFF0720
`define UAMSF_OFF_FRAC 32'hFFFF072C
`define UAMSF_OFF_IST 32'hFFFF0730
`define UAMSF_OFF_IMSK 32'hFFFF0734
`define UAMSF_OFF_MUX 32'hFFFF0738
`define UAMSF_RST_NET 8'h04
`define UAMSF_RST_LCR 8'h03
`define UAMSF_RST_DIV 16'h0001
`define UAMSF_RST_FRAC 16'h0000
`define UAMSF_RST_SCR 8'h00
`define UAMSF_FRAC_EN 15
`define UAMSF_NET_NETWORK_MODE_ENABLE 7
`define UAMSF_NET_E9BT 6
`define UAMSF_NET_NINE_BIT_WORD_SELECT 3
`define UAMSF_NET_ETD 2
`define UAMSF_NET_NAB 0
`define UAMSF_LCR_STB 2
`define UAMSF_LCR_PEN 3
`define UAMSF_LCR_EPS 4
`define UAMSF_MCR_DTR 0
`define UAMSF_MCR_RTS 1
`define UAMSF_FRAC_ONE 14'h0800
`define UAMSF_ACC_STEP 31'h0000_0800
`define UAMSF_TICK_LAST 4'hF
`define UAMSF_TICK_MID 4'h7
`endif

// ===== verilog/uamsf_pkg.sv
/*
  Types of the serial port block: modem inputs, pin function codes, pin drive
  carrier and engine states. Assumes nothing of its surroundings.
*/
package uamsf_pkg;
  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } uamsf_modem_s;
  typedef enum logic [1:0] {UAMSF_PIN_GPIO, UAMSF_PIN_UART, UAMSF_PIN_ALT, UAMSF_PIN_PLA} uamsf_pin_e;
  typedef struct packed {
    logic [9:0] oe;
    logic [9:0] out;
  } uamsf_pins_s;
  typedef enum logic {UAMSF_TX_IDLE, UAMSF_TX_SEND} uamsf_tx_e;
  typedef enum logic [1:0] {UAMSF_RX_IDLE, UAMSF_RX_START, UAMSF_RX_DATA} uamsf_rx_e;
endpackage
